// ===== erc_pkg.sv
package erc_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] FRAMING_CONTROL_ADDR = 8'h2C; // index 0x0B times four
  localparam logic [7:0] SYNC_STATUS_ADDR = 8'h30;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h34;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h38;
  localparam logic [3:0] FRAMING_CONTROL_IDX = 4'hB;
  localparam logic [7:0] FRAMING_CONTROL_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam int FORCE_BIT = 7;
  localparam int CAS_LSB = 5;
  localparam int CRC_LSB = 3;
  localparam int FAS_LSB = 0;
  localparam int IRQ_FAS_BIT = 0;
  localparam int IRQ_CRC_BIT = 1;
  localparam int IRQ_CAS_BIT = 2;
  localparam int CRC_WINDOW_MS = 1000;
  localparam int CRC_WINDOW_LIMIT = 915;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ERC_SEARCH,
    ERC_INSYNC
  } erc_state_e;
endpackage

// ===== erc_resync_ctrl.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module erc_resync_ctrl #(
  parameter int CLK_HZ = 200000000,
  parameter int SEC_CYCLES = CLK_HZ / 1000 * erc_pkg::CRC_WINDOW_MS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [erc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [erc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Alignment checks from receive framer, one pulse per checked signal
  input wire logic fas_check,
  input wire logic fas_error,
  input wire logic crc_check,
  input wire logic crc_error,
  input wire logic cas_check,
  input wire logic cas_error,
  input wire logic sync_found,
  // Framer control and status
  output logic resync_start,
  output logic fas_sync_lost,
  output logic crc_sync_lost,
  output logic cas_sync_lost,
  output logic irq
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [2:0] ists_q, ists_d, imask_q, imask_d;
  logic [3:0] cas_cnt_q, cas_cnt_d;
  logic [3:0] crc_cnt_q, crc_cnt_d;
  logic [9:0] crc_win_q, crc_win_d;
  logic [31:0] sec_q, sec_d;
  logic [2:0] fas_cnt_q, fas_cnt_d;
  logic resync_q, resync_d;
  logic fas_lost_q, fas_lost_d, crc_lost_q, crc_lost_d, cas_lost_q, cas_lost_d;
  logic [erc_pkg::AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  erc_pkg::erc_state_e state_q, state_d;
  logic do_write, force_wr;
  logic [3:0] cas_lim, crc_lim;
  logic fas_trip, crc_trip, cas_trip;

  // Bus front end: address and data latch independently
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign force_wr = do_write && (awaddr_q == erc_pkg::FRAMING_CONTROL_ADDR) && wstrb_q[0]
    && wdata_q[erc_pkg::FORCE_BIT];

  always_comb begin
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d = s_axi_awaddr;
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_held_d = 1'b1;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      unique case (awaddr_q)
        erc_pkg::FRAMING_CONTROL_ADDR, erc_pkg::IRQ_STATUS_ADDR, erc_pkg::IRQ_MASK_ADDR:
          bresp_d = erc_pkg::AXI_OKAY;
        default: bresp_d = erc_pkg::AXI_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = erc_pkg::AXI_OKAY;
      rdata_d = 32'h00000000;
      unique case (s_axi_araddr)
        erc_pkg::FRAMING_CONTROL_ADDR: rdata_d = {24'h000000, ctrl_q};
        erc_pkg::SYNC_STATUS_ADDR: rdata_d = {28'h0000000, state_q == erc_pkg::ERC_INSYNC,
          cas_lost_q, crc_lost_q, fas_lost_q};
        erc_pkg::IRQ_STATUS_ADDR: rdata_d = {29'h00000000, ists_q};
        erc_pkg::IRQ_MASK_ADDR: rdata_d = {29'h00000000, imask_q};
        default: rresp_d = erc_pkg::AXI_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Thresholds from the criteria fields
  always_comb begin
    unique case (ctrl_q[erc_pkg::CAS_LSB +: 2])
      2'h0: cas_lim = 4'h2;
      2'h1: cas_lim = 4'h3;
      2'h2: cas_lim = 4'h4;
      default: cas_lim = 4'h8;
    endcase
    unique case (ctrl_q[erc_pkg::CRC_LSB +: 2])
      2'h0: crc_lim = 4'h4;
      2'h1: crc_lim = 4'h2;
      default: crc_lim = 4'h8;
    endcase
  end

  // A trip is the error that completes the run
  assign cas_trip = cas_check && cas_error && (cas_cnt_q + 4'h1 >= cas_lim);
  // Mode 11 counts errors inside the one second window, cleared by a good CRC
  assign crc_trip = crc_check && crc_error && ((ctrl_q[erc_pkg::CRC_LSB +: 2] == 2'h3)
    ? (crc_win_q + 10'h001 >= 10'(erc_pkg::CRC_WINDOW_LIMIT))
    : (crc_cnt_q + 4'h1 >= crc_lim));
  // Field 000 is illegal; it behaves as one here so the block never hangs
  assign fas_trip = fas_check && fas_error && ((fas_cnt_q + 3'h1 >= ctrl_q[2:0])
    || (fas_cnt_q == 3'h7));

  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ists_d = ists_q;
    state_d = state_q;
    cas_cnt_d = cas_cnt_q;
    crc_cnt_d = crc_cnt_q;
    crc_win_d = crc_win_q;
    fas_cnt_d = fas_cnt_q;
    sec_d = (sec_q == 32'(SEC_CYCLES - 1)) ? 32'h00000000 : sec_q + 32'h00000001;
    fas_lost_d = fas_lost_q;
    crc_lost_d = crc_lost_q;
    cas_lost_d = cas_lost_q;
    resync_d = force_wr;
    if (do_write && wstrb_q[0]) begin
      unique case (awaddr_q)
        erc_pkg::FRAMING_CONTROL_ADDR: ctrl_d = wdata_q[7:0];
        erc_pkg::IRQ_MASK_ADDR: imask_d = wdata_q[2:0];
        erc_pkg::IRQ_STATUS_ADDR: ists_d = ists_q & ~wdata_q[2:0];
        default: ;
      endcase
    end
    if (fas_check) fas_cnt_d = fas_error ? fas_cnt_q + 3'h1 : 3'h0;
    if (cas_check) cas_cnt_d = cas_error ? cas_cnt_q + 4'h1 : 4'h0;
    if (crc_check) crc_cnt_d = crc_error ? crc_cnt_q + 4'h1 : 4'h0;
    if (crc_check && !crc_error) crc_win_d = 10'h000;
    else if (sec_q == 32'h00000000) crc_win_d = 10'(crc_check);
    else if (crc_check) crc_win_d = crc_win_q + 10'h001;
    if (force_wr) begin
      state_d = erc_pkg::ERC_SEARCH;
      fas_cnt_d = 3'h0;
    end else if (sync_found && state_q == erc_pkg::ERC_SEARCH) begin
      state_d = erc_pkg::ERC_INSYNC;
      ctrl_d[erc_pkg::FORCE_BIT] = 1'b0;
      fas_lost_d = 1'b0;
      crc_lost_d = 1'b0;
      cas_lost_d = 1'b0;
    end
    // Trips come last so a loss beats regained alignment in one cycle
    if (fas_trip) begin
      fas_lost_d = 1'b1;
      state_d = erc_pkg::ERC_SEARCH;
      fas_cnt_d = 3'h0;
    end
    if (crc_trip) begin
      crc_lost_d = 1'b1;
      crc_cnt_d = 4'h0;
      crc_win_d = 10'h000;
    end
    if (cas_trip) begin
      cas_lost_d = 1'b1;
      cas_cnt_d = 4'h0;
    end
    // Set wins over a write-one clear in the same cycle
    ists_d = ists_d | {cas_trip, crc_trip, fas_trip};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= erc_pkg::FRAMING_CONTROL_RST;
      imask_q <= erc_pkg::IRQ_MASK_RST;
      ists_q <= 3'h0;
      state_q <= erc_pkg::ERC_SEARCH;
      cas_cnt_q <= 4'h0;
      crc_cnt_q <= 4'h0;
      crc_win_q <= 10'h000;
      fas_cnt_q <= 3'h0;
      sec_q <= 32'h00000000;
      resync_q <= 1'b0;
      fas_lost_q <= 1'b0;
      crc_lost_q <= 1'b0;
      cas_lost_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      ists_q <= ists_d;
      state_q <= state_d;
      cas_cnt_q <= cas_cnt_d;
      crc_cnt_q <= crc_cnt_d;
      crc_win_q <= crc_win_d;
      fas_cnt_q <= fas_cnt_d;
      sec_q <= sec_d;
      resync_q <= resync_d;
      fas_lost_q <= fas_lost_d;
      crc_lost_q <= crc_lost_d;
      cas_lost_q <= cas_lost_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign resync_start = resync_q;
  assign fas_sync_lost = fas_lost_q;
  assign crc_sync_lost = crc_lost_q;
  assign cas_sync_lost = cas_lost_q;
  assign irq = |(ists_q & imask_q);

  property p_force_start;
    @(posedge aclk) disable iff (!aresetn)
      force_wr |=> resync_start && state_q == erc_pkg::ERC_SEARCH;
  endproperty
  a_force_start: assert property (p_force_start) else $error("no restart on force");

  property p_force_clear;
    @(posedge aclk) disable iff (!aresetn)
      (sync_found && !force_wr && state_q == erc_pkg::ERC_SEARCH) |=> !ctrl_q[erc_pkg::FORCE_BIT];
  endproperty
  a_force_clear: assert property (p_force_clear) else $error("force bit not cleared");

  property p_cas_two;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[6:5] == 2'h0 && cas_check && cas_error && cas_cnt_q == 4'h1) |=> cas_sync_lost;
  endproperty
  a_cas_two: assert property (p_cas_two) else $error("CAS loss not after two");

  property p_cas_three;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[6:5] == 2'h1 && cas_check && cas_error && cas_cnt_q == 4'h1) |-> !cas_trip;
  endproperty
  a_cas_three: assert property (p_cas_three) else $error("CAS loss too early");

  property p_cas_eight;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[6:5] == 2'h3 && cas_trip) |-> cas_cnt_q == 4'h7;
  endproperty
  a_cas_eight: assert property (p_cas_eight) else $error("CAS eight threshold wrong");

  property p_crc_four;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[4:3] == 2'h0 && crc_trip) |-> crc_cnt_q == 4'h3;
  endproperty
  a_crc_four: assert property (p_crc_four) else $error("CRC four threshold wrong");

  property p_crc_eight;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[4:3] == 2'h2 && crc_trip) |-> crc_cnt_q == 4'h7;
  endproperty
  a_crc_eight: assert property (p_crc_eight) else $error("CRC eight threshold wrong");

  property p_crc_915;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[4:3] == 2'h3 && crc_trip) |-> crc_win_q == 10'd914;
  endproperty
  a_crc_915: assert property (p_crc_915) else $error("CRC 915 threshold wrong");

  property p_fas_count;
    @(posedge aclk) disable iff (!aresetn)
      (fas_trip && ctrl_q[2:0] != 3'h0) |-> fas_cnt_q == ctrl_q[2:0] - 3'h1;
  endproperty
  a_fas_count: assert property (p_fas_count) else $error("FAS threshold wrong");

  property p_good_clears;
    @(posedge aclk) disable iff (!aresetn) (cas_check && !cas_error) |=> cas_cnt_q == 4'h0;
  endproperty
  a_good_clears: assert property (p_good_clears) else $error("CAS run not reset");
endmodule

// ===== erc_line_model.sv
`timescale 1ns/1ps
module erc_line_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench request: kind 0 FAS, 1 CRC, 2 CAS, 3 alignment regained
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_err,
  // Alignment results toward the block
  output logic fas_check,
  output logic fas_error,
  output logic crc_check,
  output logic crc_error,
  output logic cas_check,
  output logic cas_error,
  output logic sync_found
);
  logic [3:0] hit_q;
  logic err_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q <= 4'h0;
      err_q <= 1'b0;
    end else begin
      hit_q <= req_valid ? (4'h1 << req_kind) : 4'h0;
      // Error line toggles outside checks so a stale level is never a hint
      err_q <= req_valid ? req_err : ~err_q;
    end
  end
  assign fas_check = hit_q[0];
  assign crc_check = hit_q[1];
  assign cas_check = hit_q[2];
  assign sync_found = hit_q[3];
  assign fas_error = err_q;
  assign crc_error = err_q;
  assign cas_error = err_q;
endmodule

// ===== erc_resync_ctrl_tb.sv
`timescale 1ns/1ps
module erc_resync_ctrl_tb;
  // Long window keeps the whole 915-error run inside the first second
  localparam int SEC = 50000;
  typedef struct {logic [1:0] kind; logic [2:0] field; int n;} erc_row_s;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [erc_pkg::AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, req_kind;
  logic fas_check, fas_error, crc_check, crc_error, cas_check, cas_error, sync_found;
  logic resync_start, fas_sync_lost, crc_sync_lost, cas_sync_lost, irq, req_valid, req_err;
  logic [2:0] lost_v;
  int err_total, comparisons, starts;
  erc_row_s rows [14];
  assign lost_v = {cas_sync_lost, crc_sync_lost, fas_sync_lost};
  erc_resync_ctrl #(.SEC_CYCLES(SEC)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fas_check, .fas_error, .crc_check, .crc_error,
    .cas_check, .cas_error, .sync_found, .resync_start, .fas_sync_lost, .crc_sync_lost,
    .cas_sync_lost, .irq);
  erc_line_model line_u (.aclk, .aresetn, .req_valid, .req_kind, .req_err, .fas_check,
    .fas_error, .crc_check, .crc_error, .cas_check, .cas_error, .sync_found);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (resync_start === 1'b1) starts++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    err_total++;
    print_verdict();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, r_hit;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    err_total++;
    print_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    check({30'h0, rsp}, {30'h0, erc_pkg::AXI_OKAY}, "write response");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    axi_rd(a, rd, rsp);
    check(rd, exp, msg);
  endtask
  task automatic line(input logic [1:0] k, input logic e, input int cnt);
    repeat (cnt) begin
      @(posedge aclk);
      req_valid <= 1'b1;
      req_kind <= k;
      req_err <= e;
      @(posedge aclk);
      req_valid <= 1'b0;
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge aclk);
    #1;
  endtask
  // Loss flags drop only on reset or when a search ends, so force one first
  task automatic clear_loss(input logic [31:0] c);
    wr(erc_pkg::FRAMING_CONTROL_ADDR, c | (32'h1 << erc_pkg::FORCE_BIT));
    line(2'h3, 1'b0, 1);
  endtask
  initial begin
    logic [31:0] ctrl;
    int lsb;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_kind, req_valid, req_err} = 52'h0;
    s_axi_wstrb = 4'hF;
    rows = '{'{2'h0, 3'h1, 1}, '{2'h0, 3'h2, 2}, '{2'h0, 3'h3, 3}, '{2'h0, 3'h4, 4},
      '{2'h0, 3'h5, 5}, '{2'h0, 3'h6, 6}, '{2'h0, 3'h7, 7}, '{2'h1, 3'h0, 4},
      '{2'h1, 3'h1, 2}, '{2'h1, 3'h2, 8}, '{2'h2, 3'h0, 2}, '{2'h2, 3'h1, 3},
      '{2'h2, 3'h2, 4}, '{2'h2, 3'h3, 8}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check({28'h0, irq, lost_v}, 32'h0, "outputs after reset");
    rd_chk(erc_pkg::FRAMING_CONTROL_ADDR, 32'h0, "control reset");
    rd_chk(erc_pkg::IRQ_MASK_ADDR, 32'h0, "mask reset");
    axi_rd(8'h3C, rd, rsp);
    check({30'h0, rsp}, {30'h0, erc_pkg::AXI_SLVERR}, "unmapped read");
    axi_wr(8'h3C, 32'h0, rsp);
    check({30'h0, rsp}, {30'h0, erc_pkg::AXI_SLVERR}, "unmapped write");
    // CRC field 11, interrupt still masked
    wr(erc_pkg::FRAMING_CONTROL_ADDR, 32'h1F);
    line(2'h3, 1'b0, 1);
    line(2'h1, 1'b1, 914);
    settle();
    check({31'h0, crc_sync_lost}, 32'h0, "crc 914 errors");
    line(2'h1, 1'b1, 1);
    settle();
    check({28'h0, irq, lost_v}, 32'h2, "crc 915 errors");
    rd_chk(erc_pkg::IRQ_STATUS_ADDR, 32'h2, "crc event");
    wr(erc_pkg::IRQ_STATUS_ADDR, 32'h7);
    clear_loss(32'h07);
    wr(erc_pkg::IRQ_MASK_ADDR, 32'h7);
    foreach (rows[i]) begin
      lsb = (rows[i].kind == 2'h0) ? erc_pkg::FAS_LSB :
        (rows[i].kind == 2'h1) ? erc_pkg::CRC_LSB : erc_pkg::CAS_LSB;
      ctrl = 32'(rows[i].field) << lsb;
      if (rows[i].kind != 2'h0) ctrl = ctrl | 32'h7;
      clear_loss(ctrl);
      line(rows[i].kind, 1'b1, rows[i].n - 1);
      line(rows[i].kind, 1'b0, 1);
      line(rows[i].kind, 1'b1, rows[i].n - 1);
      settle();
      check({29'h0, lost_v}, 32'h0, "short run");
      line(rows[i].kind, 1'b1, 1);
      settle();
      check({29'h0, lost_v}, 32'h1 << rows[i].kind,
        "threshold");
      check({31'h0, irq}, 32'h1, "irq raised");
      rd_chk(erc_pkg::IRQ_STATUS_ADDR, 32'h1 << rows[i].kind, "event bit");
      wr(erc_pkg::IRQ_STATUS_ADDR, 32'h7);
      clear_loss(ctrl);
      settle();
      check({28'h0, irq, lost_v}, 32'h0, "cleared");
    end
    lsb = starts;
    wr(erc_pkg::FRAMING_CONTROL_ADDR, 32'h87);
    settle();
    check(32'(starts - lsb), 32'h1, "force pulse");
    rd_chk(erc_pkg::FRAMING_CONTROL_ADDR, 32'h87, "force held");
    rd_chk(erc_pkg::SYNC_STATUS_ADDR, 32'h0, "searching");
    line(2'h3, 1'b0, 1);
    settle();
    rd_chk(erc_pkg::FRAMING_CONTROL_ADDR, 32'h07, "force cleared");
    rd_chk(erc_pkg::SYNC_STATUS_ADDR, 32'h8, "in sync");
    // Mid-run reset drops a declared loss and the register contents
    wr(erc_pkg::FRAMING_CONTROL_ADDR, 32'h01);
    line(2'h0, 1'b1, 1);
    settle();
    check({28'h0, irq, lost_v}, 32'h9, "loss before reset");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check({28'h0, irq, lost_v}, 32'h0, "outputs after mid reset");
    rd_chk(erc_pkg::FRAMING_CONTROL_ADDR, 32'h0, "control after reset");
    rd_chk(erc_pkg::IRQ_MASK_ADDR, 32'h0, "mask after reset");
    rd_chk(erc_pkg::IRQ_STATUS_ADDR, 32'h0, "status after reset");
    print_verdict();
  end
endmodule
